//--- shared/ucr_defs.vh
// Constants for the capability and identification register bank
`ifndef UCR_DEFS_VH
`define UCR_DEFS_VH

// ==========================================================================
// Register byte offsets inside the peripheral bus window
`define UCR_OFS_CAPABILITY   12'h81C
`define UCR_OFS_WINDOW_SIZE  12'h820
`define UCR_OFS_LABEL_FIRST  12'h824
`define UCR_ADDR_W           12

// ==========================================================================
// Capability word field positions
`define UCR_PIPE_LSB         0
`define UCR_PIPE_MSB         3
`define UCR_CHAN_LSB         4
`define UCR_CHAN_MSB         6
`define UCR_BUFW_BIT         7
`define UCR_FDEP_LSB         8
`define UCR_FDEP_MSB         11
`define UCR_MEM_LSB          12
`define UCR_MEM_MSB          14
`define UCR_BYTE_BIT         15

// ==========================================================================
// Implemented capabilities, as counts and codes
`define UCR_PIPE_COUNT       5'h07
`define UCR_CHAN_COUNT       3'h6
`define UCR_BUFW_24          1'h0
`define UCR_FDEP_COUNT       5'h04
`define UCR_MEM_CODE         3'h2
`define UCR_BYTE_NATIVE      1'h0
`define UCR_CAP_UPPER        16'h0001
`define UCR_CAP_VALUE        32'h00012467

// ==========================================================================
// Fixed read values
`define UCR_WINDOW_VALUE     32'h00001000
`define UCR_MEM_BASE_BYTES   17'h00100
`define UCR_BUFW_NARROW      5'h10
`define UCR_BUFW_WIDE        5'h18

`endif

//--- src/ucr_cap_pack.v
// Assembles the capability word from the implemented feature set
`timescale 1ns/100ps
`default_nettype none
`include "ucr_defs.vh"

module ucr_cap_pack (
    // Feature codes
    input  wire [3:0]  pipe_code,
    input  wire [2:0]  chan_code,
    input  wire        bufw_sel,
    input  wire [3:0]  fdep_code,
    input  wire [2:0]  mem_code,
    input  wire        byte_native,
    // Packed word
    output wire [31:0] cap_word
);

    // ======================================================================
    // Field layout, high bits first
    assign cap_word = {`UCR_CAP_UPPER, byte_native, mem_code, fdep_code,
                       bufw_sel, chan_code, pipe_code};

endmodule
`default_nettype wire

//--- src/ucr_capability_regs.v
// Read-only capability, window-size and name registers on the peripheral bus
`timescale 1ns/100ps
`default_nettype none
`include "ucr_defs.vh"

module ucr_capability_regs #(
    // Arbitrary neutral label, not any real product name
    parameter [31:0] LABEL_FIRST = 32'h4D41_4352
) (
    // Clock and reset
    input  wire        ref_clk,
    input  wire        rst_b,
    // Peripheral bus slave
    input  wire        bus_sel,
    input  wire        bus_write,
    input  wire [11:0] bus_addr,
    input  wire [31:0] bus_wdata,
    output reg  [31:0] bus_rdata_ff,
    output reg         bus_ack_ff,
    output reg         bus_err_ff,
    // Decoded capabilities
    output reg  [4:0]  pipe_count_ff,
    output reg  [2:0]  transfer_channel_count_ff,
    output reg         channel_code_reserved_ff,
    output reg  [4:0]  buffer_width_bits_ff,
    output reg  [4:0]  fifo_depth_words_ff,
    output reg  [16:0] packet_memory_limit_ff,
    output reg         packet_memory_unbounded_ff,
    output reg         packet_memory_byte_lanes_ff,
    output reg         cap_consistent_ff
);

    // ======================================================================
    // Feature codes
    wire [3:0]  pipe_count_code;
    wire [3:0]  fdep_code;
    wire [4:0]  pipe_count_dec;
    wire [4:0]  fdep_count_dec;
    wire [31:0] cap_word;
    wire [2:0]  chan_code;
    wire [2:0]  mem_code;

    assign chan_code = `UCR_CHAN_COUNT;
    assign mem_code  = `UCR_MEM_CODE;

    ucr_count_code #(.W(4)) u_pipe (
        .count_in  (`UCR_PIPE_COUNT),
        .code_out  (pipe_count_code),
        .code_in   (cap_word[`UCR_PIPE_MSB:`UCR_PIPE_LSB]),
        .count_out (pipe_count_dec)
    );

    ucr_count_code #(.W(4)) u_fdep (
        .count_in  (`UCR_FDEP_COUNT),
        .code_out  (fdep_code),
        .code_in   (cap_word[`UCR_FDEP_MSB:`UCR_FDEP_LSB]),
        .count_out (fdep_count_dec)
    );

    ucr_cap_pack u_pack (
        .pipe_code   (pipe_count_code),
        .chan_code   (chan_code),
        .bufw_sel    (`UCR_BUFW_24),
        .fdep_code   (fdep_code),
        .mem_code    (mem_code),
        .byte_native (`UCR_BYTE_NATIVE),
        .cap_word    (cap_word)
    );

    // ======================================================================
    // Address decode
    wire        hit_cap;
    wire        hit_win;
    wire        hit_lbl;
    wire        hit_any;
    reg  [31:0] rd_word;

    // Word compare only, the two byte-lane bits never select a register
    localparam [11:0] OFS_CAP = `UCR_OFS_CAPABILITY;
    localparam [11:0] OFS_WIN = `UCR_OFS_WINDOW_SIZE;
    localparam [11:0] OFS_LBL = `UCR_OFS_LABEL_FIRST;

    assign hit_cap = (bus_addr[11:2] == OFS_CAP[11:2]);
    assign hit_win = (bus_addr[11:2] == OFS_WIN[11:2]);
    assign hit_lbl = (bus_addr[11:2] == OFS_LBL[11:2]);
    assign hit_any = hit_cap | hit_win | hit_lbl;

    always @* begin
        rd_word = 32'h0000_0000;
        if (hit_cap) begin
            rd_word = `UCR_CAP_VALUE;
        end else if (hit_win) begin
            rd_word = `UCR_WINDOW_VALUE;
        end else if (hit_lbl) begin
            rd_word = LABEL_FIRST;
        end
    end

    // ======================================================================
    // Bus response
    // Write data is never sampled, so a write cannot disturb any value
    wire unused_wdata;
    assign unused_wdata = ^bus_wdata;

    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            bus_rdata_ff <= 32'h0000_0000;
            bus_ack_ff   <= 1'b0;
            bus_err_ff   <= 1'b0;
        end else begin
            bus_ack_ff <= bus_sel;
            bus_err_ff <= bus_sel & ~hit_any;
            if (bus_sel && !bus_write) begin
                bus_rdata_ff <= rd_word;
            end else begin
                bus_rdata_ff <= 32'h0000_0000;
            end
        end
    end

    // ======================================================================
    // Decoded capability status
    wire [2:0]  mem_field;
    wire [16:0] mem_limit;

    assign mem_field = cap_word[`UCR_MEM_MSB:`UCR_MEM_LSB];
    assign mem_limit = `UCR_MEM_BASE_BYTES << mem_field;

    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pipe_count_ff               <= 5'h00;
            transfer_channel_count_ff   <= 3'h0;
            channel_code_reserved_ff    <= 1'b0;
            buffer_width_bits_ff        <= 5'h00;
            fifo_depth_words_ff         <= 5'h00;
            packet_memory_limit_ff      <= 17'h00000;
            packet_memory_unbounded_ff  <= 1'b0;
            packet_memory_byte_lanes_ff <= 1'b0;
            cap_consistent_ff           <= 1'b0;
        end else begin
            pipe_count_ff             <= pipe_count_dec;
            transfer_channel_count_ff <= cap_word[`UCR_CHAN_MSB:`UCR_CHAN_LSB];
            channel_code_reserved_ff  <= (cap_word[`UCR_CHAN_MSB:`UCR_CHAN_LSB] == 3'h0);
            buffer_width_bits_ff      <= cap_word[`UCR_BUFW_BIT] ? `UCR_BUFW_WIDE
                                                               : `UCR_BUFW_NARROW;
            fifo_depth_words_ff       <= fdep_count_dec;
            // Code seven only gives a lower bound, so the limit reads zero
            packet_memory_unbounded_ff <= (mem_field == 3'h7);
            packet_memory_limit_ff    <= (mem_field == 3'h7) ? 17'h00000 : mem_limit;
            packet_memory_byte_lanes_ff <= cap_word[`UCR_BYTE_BIT];
            // Packed fields must agree with the fixed read value
            cap_consistent_ff <= (cap_word == `UCR_CAP_VALUE);
        end
    end

endmodule
`default_nettype wire

//--- src/ucr_count_code.v
// Count-to-code and code-to-count for fields where code zero means sixteen
`timescale 1ns/100ps
`default_nettype none

module ucr_count_code #(
    parameter W = 4
) (
    // Count side
    input  wire [W:0]   count_in,
    output wire [W-1:0] code_out,
    // Code side
    input  wire [W-1:0] code_in,
    output wire [W:0]   count_out
);

    // ======================================================================
    // Full count wraps to code zero
    assign code_out  = count_in[W-1:0];
    assign count_out = (code_in == {W{1'b0}}) ? {1'b1, {W{1'b0}}} : {1'b0, code_in};

endmodule
`default_nettype wire

//--- verif/ucr_capability_regs_asserts.sv
// Checker for the capability register bank
`timescale 1ns/100ps
`default_nettype none
module ucr_cap_chk #(
    parameter [31:0] LABEL_FIRST = 32'h4D41_4352
) (
    // Clock, reset and bus
    input wire logic        ref_clk,
    input wire logic        rst_b,
    input wire logic        bus_sel,
    input wire logic        bus_write,
    input wire logic [11:0] bus_addr,
    input wire logic [31:0] bus_rdata_ff,
    input wire logic        bus_ack_ff,
    input wire logic        bus_err_ff,
    // Decoded status
    input wire logic [4:0]  pipe_count_ff,
    input wire logic [2:0]  transfer_channel_count_ff,
    input wire logic [4:0]  buffer_width_bits_ff,
    input wire logic [4:0]  fifo_depth_words_ff,
    input wire logic [16:0] packet_memory_limit_ff,
    input wire logic        packet_memory_byte_lanes_ff
);
    // ==========================================================
    // Properties
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    wire logic rd;
    assign rd = bus_sel && !bus_write;
    AST_CAP_RD: assert property (rd && bus_addr[11:2] == 10'h207 |=>
        bus_ack_ff && !bus_err_ff && bus_rdata_ff == 32'h00012467) else $error("cap read");
    AST_WIN_RD: assert property (rd && bus_addr[11:2] == 10'h208 |=>
        bus_ack_ff && bus_rdata_ff == 32'h00001000) else $error("window read");
    AST_NAME_RD: assert property (rd && bus_addr[11:2] == 10'h209 |=>
        bus_ack_ff && bus_rdata_ff == LABEL_FIRST) else $error("name read");
    AST_WR_IGN: assert property (bus_sel && bus_write |=>
        bus_ack_ff && bus_rdata_ff == 32'h0) else $error("write effect");
    // Status settles one edge after release, hence the past test
    AST_PIPE: assert property ($past(rst_b) |-> pipe_count_ff == 5'h07)
        else $error("pipe count");
    AST_CHAN: assert property ($past(rst_b) |-> transfer_channel_count_ff == 3'h6)
        else $error("channel count");
    AST_BUFW: assert property ($past(rst_b) |-> buffer_width_bits_ff == 5'h10)
        else $error("buffer width");
    AST_FDEP: assert property ($past(rst_b) |-> fifo_depth_words_ff == 5'h04)
        else $error("fifo depth");
    AST_MEM: assert property ($past(rst_b) |-> packet_memory_limit_ff == 17'h00400)
        else $error("memory size");
    AST_BYTE: assert property ($past(rst_b) |-> !packet_memory_byte_lanes_ff)
        else $error("byte lanes");
endmodule
`default_nettype wire

//--- verif/ucr_capability_regs_tb_top.sv
// Testbench for the capability register bank
`timescale 1ns/100ps
`default_nettype none
module ucr_capability_regs_tb_top;
    // ==========================================================
    // Signals
    localparam [31:0] LBL = 32'h5445_5354; // Arbitrary label value
    logic        ref_clk, rst_b, bus_sel, bus_write;
    logic [11:0] bus_addr;
    logic [31:0] bus_wdata, rd;
    wire  [31:0] bus_rdata_ff;
    wire         bus_ack_ff, bus_err_ff, chres, unb, lanes, cons;
    wire  [4:0]  pcnt, bufw, fdep;
    wire  [2:0]  chan;
    wire  [16:0] mlim;
    int          n_errors, check_count;
    ucr_capability_regs #(.LABEL_FIRST(LBL)) dut (.ref_clk(ref_clk), .rst_b(rst_b),
        .bus_sel(bus_sel), .bus_write(bus_write), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_rdata_ff(bus_rdata_ff), .bus_ack_ff(bus_ack_ff),
        .bus_err_ff(bus_err_ff),
        .pipe_count_ff(pcnt), .transfer_channel_count_ff(chan),
        .channel_code_reserved_ff(chres), .buffer_width_bits_ff(bufw),
        .fifo_depth_words_ff(fdep), .packet_memory_limit_ff(mlim),
        .packet_memory_unbounded_ff(unb), .packet_memory_byte_lanes_ff(lanes),
        .cap_consistent_ff(cons));
    // ==========================================================
    // Tasks
    task chk(input [31:0] got, input [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One request, one idle cycle after; returns read data
    task acc(input w, input [11:0] a, input [31:0] d, input e, output [31:0] r);
        @(posedge ref_clk);
        bus_sel <= 1'b1;
        bus_write <= w;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge ref_clk);
        bus_sel <= 1'b0;
        #1;
        chk(bus_ack_ff, 1'b1);
        chk(bus_err_ff, e);
        r = bus_rdata_ff;
    endtask
    task summarize;
        if (n_errors == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // ==========================================================
    // Stimulus
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (2000) @(posedge ref_clk);
        n_errors++;
        summarize;
    end
    initial begin
        n_errors = 0;
        check_count = 0;
        rst_b = 1'b0;
        bus_sel = 1'b0;
        bus_write = 1'b0;
        bus_addr = 12'h000;
        bus_wdata = 32'h0;
        repeat (6) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (2) begin
            acc(1'b0, 12'h81C, 32'h0, 1'b0, rd);
            chk(rd, 32'h00012467);
            acc(1'b0, 12'h820, 32'h0, 1'b0, rd);
            chk(rd, 32'h00001000);
            acc(1'b0, 12'h824, 32'h0, 1'b0, rd);
            chk(rd, LBL);
            // Writes of all ones must leave every value as it was
            for (int i = 0; i < 3; i++) begin
                acc(1'b1, 12'h81C + 12'(4 * i), 32'hFFFFFFFF, 1'b0, rd);
                chk(rd, 32'h0);
            end
        end
        acc(1'b0, 12'h828, 32'h0, 1'b1, rd);
        chk(rd, 32'h0);
        // Answer stands one cycle only, then the bus goes quiet
        @(posedge ref_clk);
        #1;
        chk({bus_ack_ff, bus_err_ff}, 2'h0);
        chk(bus_rdata_ff, 32'h0);
        chk(pcnt, 5'h07);
        chk(chan, 3'h6);
        chk(bufw, 5'h10);
        chk(fdep, 5'h04);
        chk(mlim, 17'h00400);
        chk(lanes, 1'b0);
        chk({chres, unb, cons}, 3'h1);
        summarize;
    end
endmodule
bind ucr_capability_regs ucr_cap_chk #(.LABEL_FIRST(LABEL_FIRST)) u_chk (
    .ref_clk(ref_clk), .rst_b(rst_b), .bus_sel(bus_sel), .bus_write(bus_write),
    .bus_addr(bus_addr), .bus_rdata_ff(bus_rdata_ff), .bus_ack_ff(bus_ack_ff),
    .bus_err_ff(bus_err_ff), .pipe_count_ff(pipe_count_ff),
    .transfer_channel_count_ff(transfer_channel_count_ff),
    .buffer_width_bits_ff(buffer_width_bits_ff),
    .fifo_depth_words_ff(fifo_depth_words_ff),
    .packet_memory_limit_ff(packet_memory_limit_ff),
    .packet_memory_byte_lanes_ff(packet_memory_byte_lanes_ff));
`default_nettype wire
